// ---- common/irq_sel_params.svh ----
// Offsets, field positions, reset values and codes for the interrupt selector
`ifndef IRQ_SEL_PARAMS_SVH
`define IRQ_SEL_PARAMS_SVH

`define SEL_HIGH_ADDR 32'h019C_0000
`define SEL_LOW_ADDR 32'h019C_0004
`define SEL_FIELD_W 5
`define SEL_FIELDS 6
`define SEL_RSVD_MASK 32'h7FFF_7FFF
`define SEL_LOW_RESET 32'h2507_18A4
`define SEL_HIGH_RESET 32'h0820_2D43
`define CODE_HOST 5'h00
`define CODE_TIMER0 5'h01
`define CODE_TIMER1 5'h02
`define CODE_WIDE_REFRESH 5'h03
`define CODE_PIN4 5'h04
`define CODE_PIN5 5'h05
`define CODE_PIN6 5'h06
`define CODE_PIN7 5'h07
`define CODE_DMA 5'h08
`define CODE_DBG_DMA 5'h09
`define CODE_DBG_RX 5'h0A
`define CODE_DBG_TX 5'h0B
`define CODE_SER0_TX 5'h0C
`define CODE_SER0_RX 5'h0D
`define CODE_SER1_TX 5'h0E
`define CODE_SER1_RX 5'h0F
`define CODE_GPIO0 5'h10
`define CODE_SER2_TX 5'h11
`define CODE_SER2_RX 5'h12
`define CODE_TIMER2 5'h13
`define CODE_NARROW_REFRESH 5'h14
`define CODE_CELL_BUS 5'h17
`define CODE_CONV_DEC 5'h1E
`define CODE_ITER_DEC 5'h1F

`endif

// ---- common/irq_sel_pkg.sv ----
// Types shared by the interrupt selector modules
package irq_sel_pkg;
   typedef logic [4:0] sel_code_t;
   typedef logic [31:0] sel_word_t;
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_read = 2'b01,
      bus_write = 2'b10
   } bus_phase_t;
   typedef struct packed {
      sel_word_t sel_low;
      sel_word_t sel_high;
      sel_word_t rd_data;
      bus_phase_t phase;
      logic [15:0] cpu_irq;
   } sel_state_t;
endpackage : irq_sel_pkg

// ---- common/irq_route_if.sv ----
// Interface carrying selector codes and events to the routing matrix and routed lines back
`timescale 1ns/1ps
interface irq_route_if;
   logic [31:0] events;
   logic [59:0] codes;
   logic [11:0] routed;
   modport ctrl (output events, output codes, input routed);
   modport matrix (input events, input codes, output routed);
endinterface : irq_route_if

// ---- rtl/irq_route_matrix.sv ----
// Routing matrix: each maskable CPU input picks one of 32 events
`timescale 1ns/1ps
module irq_route_matrix (
   // Codes and events
   irq_route_if.matrix rt
);
   // Pick one event by code; reserved codes see tied-low event lines
   function automatic logic pick(input logic [31:0] ev, input irq_sel_pkg::sel_code_t code);
      pick = ev[code];
   endfunction : pick

   // One selector per maskable input
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         rt.routed[i] = pick(rt.events, rt.codes[i*5 +: 5]);
      end
   end
endmodule : irq_route_matrix

// ---- rtl/cpu_interrupt_selector.sv ----
// Interrupt selector: routes peripheral events onto CPU interrupts 4 to 15
//
// Contract
// - CPU inputs 0 to 3 are fixed as reset, non-maskable, and two reserved zeros.
// - Each CPU input 4 to 15 follows the event named by its own selector field.
// - The low register holds six 5-bit fields for inputs 4 to 9 with defaults 4 to 9.
// - The high register holds six fields for inputs 10 to 15 with defaults 3,10,11,0,1,2.
// - Codes 4 to 7 route the combined GPIO or external pin events 4 to 7.
// - Code 8 routes the combined DMA completion interrupt of all 64 channels.
// - Codes 9, 10 and 11 route the debug DMA, debug exchange receive and transmit.
// - Codes 3, 0, 1 and 2 route wide refresh, host, timer 0 and timer 1.
// - Codes 12 to 20 route serial ports, GPIO event 0, timer 2 and narrow refresh.
// - Code 23 routes the cell bus and 30, 31 the decoders; reserved codes stay unused.
// - The four external interrupt pins are inputs only after reset, never driven.
// - Inputs are ordered by number, input 0 highest and input 15 lowest.
// - The high register sits at 0x019C0000 and the low one at 0x019C0004.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "irq_sel_params.svh"
module cpu_interrupt_selector (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Fixed sources
   input wire logic nmi_req,
   // Peripheral events
   input wire logic host_irq,
   input wire logic timer0_irq,
   input wire logic timer1_irq,
   input wire logic timer2_irq,
   input wire logic wide_mem_refresh_irq,
   input wire logic narrow_mem_refresh_irq,
   input wire logic [3:0] gpio_event_hi,
   input wire logic gpio_event_0,
   input wire logic dma_done_irq,
   input wire logic debug_dma_event,
   input wire logic debug_exchange_rx,
   input wire logic debug_exchange_tx,
   input wire logic serial0_tx_irq,
   input wire logic serial0_rx_irq,
   input wire logic serial1_tx_irq,
   input wire logic serial1_rx_irq,
   input wire logic serial2_tx_irq,
   input wire logic serial2_rx_irq,
   input wire logic cell_bus_irq,
   input wire logic conv_decoder_irq,
   input wire logic iter_decoder_irq,
   // External interrupt pins
   input wire logic [3:0] ext_pin_irqs_in,
   output logic [3:0] ext_pin_irqs_out,
   output logic [3:0] ext_pin_irqs_oe,
   // CPU side, bit 0 is highest priority
   output logic [15:0] cpu_irq
);
   irq_sel_pkg::sel_state_t state;
   irq_sel_pkg::sel_state_t next_state;
   logic [31:0] events;
   logic [11:0] routed;
   irq_route_if rt ();

   // Drop the reserved gaps between fields
   function automatic irq_sel_pkg::sel_word_t clean(input irq_sel_pkg::sel_word_t w);
      clean = w & `SEL_RSVD_MASK;
   endfunction : clean

   // Pins never driven; pin and GPIO event share one line each
   assign ext_pin_irqs_out = 4'h0;
   assign ext_pin_irqs_oe = 4'h0;

   // Event vector by selector code; reserved codes tied low
   always_comb begin
      events = 32'h0000_0000;
      events[`CODE_HOST] = host_irq;
      events[`CODE_TIMER0] = timer0_irq;
      events[`CODE_TIMER1] = timer1_irq;
      events[`CODE_WIDE_REFRESH] = wide_mem_refresh_irq;
      events[`CODE_PIN4] = gpio_event_hi[0] | ext_pin_irqs_in[0];
      events[`CODE_PIN5] = gpio_event_hi[1] | ext_pin_irqs_in[1];
      events[`CODE_PIN6] = gpio_event_hi[2] | ext_pin_irqs_in[2];
      events[`CODE_PIN7] = gpio_event_hi[3] | ext_pin_irqs_in[3];
      events[`CODE_DMA] = dma_done_irq;
      events[`CODE_DBG_DMA] = debug_dma_event;
      events[`CODE_DBG_RX] = debug_exchange_rx;
      events[`CODE_DBG_TX] = debug_exchange_tx;
      events[`CODE_SER0_TX] = serial0_tx_irq;
      events[`CODE_SER0_RX] = serial0_rx_irq;
      events[`CODE_SER1_TX] = serial1_tx_irq;
      events[`CODE_SER1_RX] = serial1_rx_irq;
      events[`CODE_GPIO0] = gpio_event_0;
      events[`CODE_SER2_TX] = serial2_tx_irq;
      events[`CODE_SER2_RX] = serial2_rx_irq;
      events[`CODE_TIMER2] = timer2_irq;
      events[`CODE_NARROW_REFRESH] = narrow_mem_refresh_irq;
      events[`CODE_CELL_BUS] = cell_bus_irq;
      events[`CODE_CONV_DEC] = conv_decoder_irq;
      events[`CODE_ITER_DEC] = iter_decoder_irq;
   end

   // Pack the twelve live fields for the matrix
   assign rt.events = events;
   assign rt.codes = {state.sel_high[30:26], state.sel_high[25:21], state.sel_high[20:16],
                      state.sel_high[14:10], state.sel_high[9:5], state.sel_high[4:0],
                      state.sel_low[30:26], state.sel_low[25:21], state.sel_low[20:16],
                      state.sel_low[14:10], state.sel_low[9:5], state.sel_low[4:0]};
   assign routed = rt.routed;

   irq_route_matrix u_matrix (
      .rt(rt.matrix)
   );

   // Register port and output staging
   always_comb begin
      next_state = state;
      next_state.phase = irq_sel_pkg::bus_idle;
      next_state.rd_data = 32'h0000_0000;
      if (reg_write) begin
         next_state.phase = irq_sel_pkg::bus_write;
         if (reg_addr == `SEL_HIGH_ADDR) begin
            next_state.sel_high = clean(reg_wdata);
         end else if (reg_addr == `SEL_LOW_ADDR) begin
            next_state.sel_low = clean(reg_wdata);
         end
      end else if (reg_read) begin
         next_state.phase = irq_sel_pkg::bus_read;
         case (reg_addr)
            `SEL_HIGH_ADDR: next_state.rd_data = clean(state.sel_high);
            `SEL_LOW_ADDR: next_state.rd_data = clean(state.sel_low);
            default: next_state.rd_data = 32'h0000_0000;
         endcase
      end
      // Registered output so glitchy select changes never reach the core
      next_state.cpu_irq[0] = 1'b0;
      next_state.cpu_irq[1] = nmi_req;
      next_state.cpu_irq[3:2] = 2'b00;
      next_state.cpu_irq[15:4] = routed;
   end

   // State register; reset loads the default mapping
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state.sel_low <= `SEL_LOW_RESET;
         state.sel_high <= `SEL_HIGH_RESET;
         state.rd_data <= 32'h0000_0000;
         state.phase <= irq_sel_pkg::bus_idle;
         state.cpu_irq <= 16'h0000;
      end else begin
         state <= next_state;
      end
   end

   // Reset line asserted toward the core while reset is low
   assign cpu_irq = {state.cpu_irq[15:1], ~reset_n};
   assign reg_rdata = state.rd_data;
endmodule : cpu_interrupt_selector

// ---- verif/irq_sel_monitor.sv ----
// Checker for the interrupt selector ports
`timescale 1ns/1ps
`include "irq_sel_params.svh"
module irq_sel_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register port
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // Sources and outputs
   input wire logic nmi_req,
   input wire logic timer0_irq,
   input wire logic [3:0] ext_pin_irqs_out,
   input wire logic [3:0] ext_pin_irqs_oe,
   input wire logic [15:0] cpu_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Fixed inputs ignore the selector entirely
   // Reset line tracks the sampled reset level, so the release edge itself passes
   property p_fixed; cpu_irq[3:2] == 2'b00 && cpu_irq[0] == !reset_n; endproperty
   a_fixed: assert property (p_fixed) else $error("fixed inputs moved");
   property p_nmi; 1'b1 |=> cpu_irq[1] == $past(nmi_req); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not passed through");
   property p_pins; ext_pin_irqs_oe == 4'h0 && ext_pin_irqs_out == 4'h0; endproperty
   a_pins: assert property (p_pins) else $error("pin driven");
   property p_rsvd; reg_read |=> !reg_rdata[15] && !reg_rdata[31]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("gap bit read as one");
   property p_unmapped; reg_read && reg_addr != `SEL_HIGH_ADDR && reg_addr != `SEL_LOW_ADDR
      |=> reg_rdata == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // Write then immediate readback of the same word
   property p_wr_rd_high; reg_write && reg_addr == `SEL_HIGH_ADDR ##1 reg_read && !reg_write
      && reg_addr == `SEL_HIGH_ADDR |=> reg_rdata == ($past(reg_wdata, 2) & `SEL_RSVD_MASK);
   endproperty
   a_wr_rd_high: assert property (p_wr_rd_high) else $error("high readback");
   property p_wr_rd_low; reg_write && reg_addr == `SEL_LOW_ADDR ##1 reg_read && !reg_write
      && reg_addr == `SEL_LOW_ADDR |=> reg_rdata == ($past(reg_wdata, 2) & `SEL_RSVD_MASK);
   endproperty
   a_wr_rd_low: assert property (p_wr_rd_low) else $error("low readback");
   // Input 4 follows timer 0 once its field names it
   property p_route; reg_write && reg_addr == `SEL_LOW_ADDR && reg_wdata[4:0] == `CODE_TIMER0
      ##1 !reg_write |=> cpu_irq[4] == $past(timer0_irq); endproperty
   a_route: assert property (p_route) else $error("timer 0 not routed");
   c_nmi: cover property (nmi_req ##1 cpu_irq[1]);
   c_unmapped: cover property (reg_read && reg_addr == 32'h019C_0008);
   c_route: cover property (cpu_irq[4] && timer0_irq);
endmodule : irq_sel_monitor
bind cpu_interrupt_selector irq_sel_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .nmi_req(nmi_req), .timer0_irq(timer0_irq),
   .ext_pin_irqs_out(ext_pin_irqs_out), .ext_pin_irqs_oe(ext_pin_irqs_oe), .cpu_irq(cpu_irq));

// ---- verif/irq_core_model.sv ----
// Core-side model picking the winning CPU interrupt
`timescale 1ns/1ps
module irq_core_model (
   // CPU inputs and winner, 16 when idle
   input wire logic [15:0] cpu_irq,
   output logic [4:0] winner
);
   // Scan downward so the lowest number wins
   always_comb begin
      winner = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (cpu_irq[i]) winner = 5'(i);
      end
   end
endmodule : irq_core_model

// ---- verif/tb_cpu_interrupt_selector.sv ----
// Testbench for the interrupt selector
`timescale 1ns/1ps
`include "irq_sel_params.svh"
module tb_cpu_interrupt_selector;
   typedef struct {logic [31:0] addr; logic [31:0] wd; logic [31:0] exp;} row_t;
   logic sys_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, nmi_req = 1'b0;
   logic [31:0] reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, ev = 32'h0000_0000;
   logic [3:0] pins = 4'h0;
   logic [3:0] pin_out, pin_oe;
   logic [31:0] reg_rdata;
   logic [15:0] cpu_irq;
   logic [4:0] winner;
   int error_cnt = 0, tests_run = 0;
   localparam logic [31:0] LOW_DEF = {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05, 5'h04};
   localparam logic [31:0] HIGH_DEF = {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0B, 5'h0A, 5'h03};
   localparam logic [31:0] VALID = 32'hC09F_FFFF; // Codes that name a real source
   row_t rows [4] = '{'{`SEL_HIGH_ADDR, 32'hFFFF_FFFF, 32'h7FFF_7FFF},
      '{`SEL_LOW_ADDR, 32'h8000_8000, 32'h0000_0000},
      '{`SEL_LOW_ADDR, 32'h5A5A_A5A5, 32'h5A5A_25A5},
      '{32'h019C_0008, 32'hFFFF_FFFF, 32'h0000_0000}};
   cpu_interrupt_selector uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .nmi_req(nmi_req), .host_irq(ev[0]), .timer0_irq(ev[1]), .timer1_irq(ev[2]),
      .wide_mem_refresh_irq(ev[3]), .gpio_event_hi(ev[7:4]), .dma_done_irq(ev[8]),
      .debug_dma_event(ev[9]), .debug_exchange_rx(ev[10]), .debug_exchange_tx(ev[11]),
      .serial0_tx_irq(ev[12]), .serial0_rx_irq(ev[13]), .serial1_tx_irq(ev[14]),
      .serial1_rx_irq(ev[15]), .gpio_event_0(ev[16]), .serial2_tx_irq(ev[17]),
      .serial2_rx_irq(ev[18]), .timer2_irq(ev[19]), .narrow_mem_refresh_irq(ev[20]),
      .cell_bus_irq(ev[23]), .conv_decoder_irq(ev[30]), .iter_decoder_irq(ev[31]),
      .ext_pin_irqs_in(pins), .ext_pin_irqs_out(pin_out), .ext_pin_irqs_oe(pin_oe),
      .cpu_irq(cpu_irq));
   irq_core_model core (.cpu_irq(cpu_irq), .winner(winner));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim();
      if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // Optional write, then a read of that word in the very next cycle
   task automatic acc(input logic [31:0] a, d, input bit w, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= w;
      reg_read <= !w;
      if (w) begin
         @(posedge sys_clk);
         reg_write <= 1'b0;
         reg_read <= 1'b1;
      end
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : acc
   // Aim CPU input 4 at a code, then drive events and pins
   task automatic route(input logic [4:0] c, input logic [31:0] e, input logic [3:0] p,
      input logic x);
      acc(`SEL_LOW_ADDR, {27'h000_0000, c}, 1'b1, {27'h000_0000, c});
      @(posedge sys_clk);
      ev <= e;
      pins <= p;
      repeat (2) @(posedge sys_clk);
      #1 chk({31'h0000_0000, cpu_irq[4]}, {31'h0000_0000, x});
   endtask : route
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (19) @(posedge sys_clk);
      #1 chk({16'h0000, cpu_irq}, 32'h0000_0001);
      chk({27'h000_0000, winner}, 32'h0000_0000);
      // Release on the 20th edge, by non-blocking assignment
      @(posedge sys_clk);
      reset_n <= 1'b1;
      acc(`SEL_LOW_ADDR, 32'h0000_0000, 1'b0, LOW_DEF);
      acc(`SEL_HIGH_ADDR, 32'h0000_0000, 1'b0, HIGH_DEF);
      @(posedge sys_clk);
      ev <= 32'h0000_0002;
      nmi_req <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk({16'h0000, cpu_irq}, 32'h0000_4002);
      chk({27'h000_0000, winner}, 32'h0000_0001);
      @(posedge sys_clk);
      nmi_req <= 1'b0;
      ev <= 32'h0000_0000;
      foreach (rows[i]) acc(rows[i].addr, rows[i].wd, 1'b1, rows[i].exp);
      // Lone event must pass, every other event high must not leak
      for (int c = 0; c < 32; c++) begin
         // Software keeps off the reserved codes
         if (VALID[c]) begin
            route(5'(c), 32'h0000_0001 << c, 4'h0, VALID[c]);
            route(5'(c), ~(32'h0000_0001 << c), 4'h0, 1'b0);
         end
      end
      route(5'h06, 32'h0000_0000, 4'h4, 1'b1);
      chk({24'h00_0000, pin_oe, pin_out}, 32'h0000_0000);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      #1 chk({16'h0000, cpu_irq}, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      acc(`SEL_LOW_ADDR, 32'h0000_0000, 1'b0, LOW_DEF);
      end_sim();
   end
endmodule : tb_cpu_interrupt_selector
